// File: common/port_e_pkg.sv
// package: register map, field layouts, reset values and mode encodings of the control-port mux
package port_e_pkg;
    // register byte offsets on the 32-bit bus
    localparam logic [7:0] DirOff   = 8'h00;
    localparam logic [7:0] FselOff  = 8'h04;
    localparam logic [7:0] PullOff  = 8'h08;
    localparam logic [7:0] DriveOff = 8'h0C;

    // bus responses
    localparam logic [1:0] RespOk     = 2'h0;
    localparam logic [1:0] RespDecErr = 2'h3;

    // mode byte (byte lane 1 of the function-select word)
    localparam int unsigned EstrBit = 0;
    localparam int unsigned EmeBit  = 1;
    localparam int unsigned IvisBit = 3;

    // pull-up and drive control fields
    localparam int unsigned HighPortBit = 0;
    localparam int unsigned LowPortBit  = 1;
    localparam int unsigned CtrlPortBit = 4;

    // pin masks of the control port
    localparam logic [7:0] InputOnlyMask = 8'h03;
    localparam logic [7:0] PullableMask  = 8'h8D;
    localparam logic [7:0] AlwaysPullMsk = 8'h02;

    // reset values
    localparam logic [7:0] DirRst       = 8'h00;
    localparam logic [7:0] PullRst      = 8'h00;
    localparam logic [7:0] DriveRst     = 8'h00;
    localparam logic [7:0] ModeBitsRst  = 8'h00;
    localparam logic [7:0] FselRstNorm1 = 8'h90;
    localparam logic [7:0] FselRstSpec1 = 8'h80;
    localparam logic [7:0] FselRstNormX = 8'h80;
    localparam logic [7:0] FselRstSpecX = 8'hAC;

    // operating modes as strapped: bit2 normal, bit0 expanded, bit1 wide when expanded (peripheral when bit1 is set and bit0 and bit2 are clear)
    typedef enum logic [2:0] {
        ModeSpecSingle  = 3'h0,
        ModeSpecExpNar  = 3'h1,
        ModePeriph      = 3'h2,
        ModeSpecExpWide = 3'h3,
        ModeNormSingle  = 3'h4,
        ModeNormExpNar  = 3'h5,
        ModeNormExpWide = 3'h7
    } op_mode_e;

    // function-select register layout
    typedef struct packed {
        logic       dataBusEnableDisable;
        logic       clockGenTestOutEn;
        logic       pipeStatusOutEn;
        logic       busClockPinDisable;
        logic       lowStrobePinEn;
        logic       readWritePinEn;
        logic [1:0] rsvd;
    } fsel_s;
endpackage

// File: src/port_e_function_and_pad_control.sv
// control-port function select, direction, pull-up and drive logic with an AXI4-Lite slave
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module port_e_function_and_pad_control #(
    parameter int unsigned AddrW = 8 // bus address width
) (
    input  wire logic             ref_clk,           // system clock, 100 MHz
    input  wire logic             rst_n,             // synchronous reset, active low
    input  wire logic [AddrW-1:0] s_axi_awaddr,      // write address
    input  wire logic             s_axi_awvalid,     // write address valid
    output logic                  s_axi_awready,     // write address ready
    input  wire logic [31:0]      s_axi_wdata,       // write data
    input  wire logic [3:0]       s_axi_wstrb,       // write byte enables
    input  wire logic             s_axi_wvalid,      // write data valid
    output logic                  s_axi_wready,      // write data ready
    output logic [1:0]            s_axi_bresp,       // write response
    output logic                  s_axi_bvalid,      // write response valid
    input  wire logic             s_axi_bready,      // write response ready
    input  wire logic [AddrW-1:0] s_axi_araddr,      // read address
    input  wire logic             s_axi_arvalid,     // read address valid
    output logic                  s_axi_arready,     // read address ready
    output logic [31:0]           s_axi_rdata,       // read data
    output logic [1:0]            s_axi_rresp,       // read response
    output logic                  s_axi_rvalid,      // read data valid
    input  wire logic             s_axi_rready,      // read data ready
    input  wire logic [2:0]       modePins,          // operating mode straps
    input  wire logic [7:0]       pinIn,             // control-port pad levels
    output logic [7:0]            pinOut,            // control-port pad drive values
    output logic [7:0]            pinOe,             // control-port pad enables
    output logic [7:0]            pinLevel,          // synchronised pad levels
    input  wire logic [7:0]       gpioOut,           // port data register value
    output logic [7:0]            pullEnE,           // control-port pull-ups
    output logic [7:0]            pullEnA,           // high wide-port pull-ups
    output logic [7:0]            pullEnB,           // low wide-port pull-ups
    input  wire logic [7:0]       portADir,          // high wide-port directions
    input  wire logic [7:0]       portBDir,          // low wide-port directions
    output logic                  lowDriveE,         // control-port reduced drive
    output logic                  lowDriveA,         // high wide-port reduced drive
    output logic                  lowDriveB,         // low wide-port reduced drive
    input  wire logic             dataEnableOut,     // data enable from bus logic
    input  wire logic             busClk,            // bus clock from bus logic
    input  wire logic             rdWr,              // read/write from bus logic
    input  wire logic             lowByteStrobe,     // low-byte strobe from bus logic
    input  wire logic [1:0]       pipeStatus,        // instruction queue state
    input  wire logic             clockGenTest,      // clock generator test signal
    input  wire logic             tagEnable,         // debug instruction tagging on
    output logic                  lowByteTagInput,   // low-byte tag seen at clock fall
    output logic                  emulateCtrlPort    // port registers are external
);

    // two-flop synchronisers for straps and pads
    logic [2:0] modeMeta_q;
    logic [2:0] modeSync_q;
    logic [7:0] pinMeta_q;
    logic [7:0] pinSync_q;
    always_ff @(posedge ref_clk) begin
        modeMeta_q <= modePins;
        modeSync_q <= modeMeta_q;
        pinMeta_q  <= pinIn;
        pinSync_q  <= pinMeta_q;
    end

    // unused strap code falls back to normal single-chip
    function automatic port_e_pkg::op_mode_e decodeMode(input logic [2:0] raw);
        decodeMode = (raw == 3'h6) ? port_e_pkg::ModeNormSingle : port_e_pkg::op_mode_e'(raw);
    endfunction

    // mode-dependent reset value of the function select
    function automatic logic [7:0] fselReset(input port_e_pkg::op_mode_e m);
        unique case (m)
            port_e_pkg::ModeSpecSingle:  fselReset = port_e_pkg::FselRstSpec1;
            port_e_pkg::ModeNormExpNar,
            port_e_pkg::ModeNormExpWide: fselReset = port_e_pkg::FselRstNormX;
            port_e_pkg::ModeSpecExpNar,
            port_e_pkg::ModeSpecExpWide: fselReset = port_e_pkg::FselRstSpecX;
            default:                     fselReset = port_e_pkg::FselRstNorm1;
        endcase
    endfunction

    // one-hot select of dir, fsel, pull, drive; zero when absent from the map
    function automatic logic [3:0] regSel(input logic [AddrW-1:0] a,
                                          input logic periph,
                                          input logic dirGone);
        logic [7:0] w;
        w = 8'(a) & 8'hFC;
        regSel[0] = (w == port_e_pkg::DirOff) && !dirGone;
        regSel[1] = (w == port_e_pkg::FselOff) && !periph;
        regSel[2] = (w == port_e_pkg::PullOff) && !periph;
        regSel[3] = (w == port_e_pkg::DriveOff) && !periph;
    endfunction

    port_e_pkg::op_mode_e opMode_q;
    port_e_pkg::fsel_s    fsel_q;
    port_e_pkg::fsel_s    fsel_d;
    port_e_pkg::fsel_s    wFsel;
    logic [7:0]           dir_q;
    logic [7:0]           pull_q;
    logic [7:0]           drive_q;
    logic                 internal_visibility_q;
    logic                 eme_q;
    logic                 clock_stretch_select_q;
    logic                 fselOnce_q;
    logic                 eclkOnce_q;
    logic                 driveOnce_q;

    // mode flags
    wire isSpecial  = !opMode_q[2];
    wire isSingle   = (opMode_q[1:0] == 2'b00);
    wire isExpanded = opMode_q[0];
    wire isPeriph   = (opMode_q == port_e_pkg::ModePeriph);
    wire dirGone    = isPeriph || (isExpanded && eme_q);

    // bus write and read channel state
    logic             awHeld_q;
    logic             wHeld_q;
    logic [AddrW-1:0] awAddr_q;
    logic [31:0]      wData_q;
    logic [3:0]       wStrb_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;

    // write decode and lock qualification
    wire [3:0] wSel    = regSel(awAddr_q, isPeriph, dirGone);
    wire       doWrite = awHeld_q && wHeld_q && !bvalid_q;
    wire       wrDir   = doWrite && wSel[0] && wStrb_q[0];
    wire       wrFsel  = doWrite && wSel[1] && wStrb_q[0];
    wire       wrMode  = doWrite && wSel[1] && wStrb_q[1];
    wire       wrPull  = doWrite && wSel[2] && wStrb_q[0];
    wire       wrDrive = doWrite && wSel[3] && wStrb_q[0];
    wire       onceOk  = isSpecial ? fselOnce_q : !fselOnce_q;
    wire       driveOk = isSpecial ? driveOnce_q : !driveOnce_q;
    wire       eclkOk  = !isExpanded && (isSpecial || !eclkOnce_q);
    assign wFsel = port_e_pkg::fsel_s'(wData_q[7:0]);

    // next function select: lock-qualified fields, clock-disable forced low when expanded
    always_comb begin
        fsel_d = fsel_q;
        if (wrFsel && onceOk) begin
            fsel_d.dataBusEnableDisable = wFsel.dataBusEnableDisable;
            fsel_d.clockGenTestOutEn    = wFsel.clockGenTestOutEn;
            fsel_d.pipeStatusOutEn      = wFsel.pipeStatusOutEn;
            fsel_d.lowStrobePinEn       = wFsel.lowStrobePinEn;
            fsel_d.readWritePinEn       = wFsel.readWritePinEn;
        end
        if (wrFsel && eclkOk) begin
            fsel_d.busClockPinDisable = wFsel.busClockPinDisable;
        end
        if (isExpanded) begin
            fsel_d.busClockPinDisable = 1'b0;
        end
        fsel_d.rsvd = 2'b00;
    end

    // mode capture and control registers; locks clear only by reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            opMode_q    <= decodeMode(modeSync_q);
            fsel_q      <= port_e_pkg::fsel_s'(fselReset(decodeMode(modeSync_q)));
            dir_q       <= port_e_pkg::DirRst;
            pull_q      <= port_e_pkg::PullRst;
            drive_q     <= port_e_pkg::DriveRst;
            internal_visibility_q      <= port_e_pkg::ModeBitsRst[port_e_pkg::IvisBit];
            eme_q       <= port_e_pkg::ModeBitsRst[port_e_pkg::EmeBit];
            clock_stretch_select_q      <= port_e_pkg::ModeBitsRst[port_e_pkg::EstrBit];
            fselOnce_q  <= 1'b0;
            eclkOnce_q  <= 1'b0;
            driveOnce_q <= 1'b0;
        end else begin
            fsel_q <= fsel_d;
            if (wrDir) begin
                dir_q <= wData_q[7:0] & ~port_e_pkg::InputOnlyMask;
            end
            if (wrMode) begin
                internal_visibility_q <= wData_q[8 + port_e_pkg::IvisBit];
                eme_q  <= wData_q[8 + port_e_pkg::EmeBit];
                clock_stretch_select_q <= wData_q[8 + port_e_pkg::EstrBit];
            end
            if (wrPull) begin
                pull_q <= wData_q[7:0];
            end
            if (wrDrive && driveOk) begin
                drive_q <= wData_q[7:0];
            end
            if (wrFsel) begin
                fselOnce_q <= 1'b1;
                eclkOnce_q <= 1'b1;
            end
            if (wrDrive) begin
                driveOnce_q <= 1'b1;
            end
        end
    end

    // write channel: address and data taken in either order, response after both
    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready  = !wHeld_q && !bvalid_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= '0;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= port_e_pkg::RespOk;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (|wSel) ? port_e_pkg::RespOk : port_e_pkg::RespDecErr;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // read decode and readback mux
    wire [3:0]  rSel     = regSel(s_axi_araddr, isPeriph, dirGone);
    wire [7:0]  modeByte = {4'h0, internal_visibility_q, 1'b0, eme_q, clock_stretch_select_q} &
                           8'((1 << port_e_pkg::IvisBit) | (1 << port_e_pkg::EmeBit) |
                              (1 << port_e_pkg::EstrBit));
    wire [31:0] rdValue  = ({32{rSel[0]}} & {24'h00_0000, dir_q}) |
                           ({32{rSel[1]}} & {16'h0000, modeByte, 8'(fsel_q)}) |
                           ({32{rSel[2]}} & {24'h00_0000, pull_q}) |
                           ({32{rSel[3]}} & {24'h00_0000, drive_q});

    // read channel: one read at a time, data one cycle after the address
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= port_e_pkg::RespOk;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rdValue;
            rresp_q  <= (|rSel) ? port_e_pkg::RespOk : port_e_pkg::RespDecErr;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // alternate function enables per pin
    wire pipeOn = fsel_q.pipeStatusOutEn && !isSingle;
    wire cgmOn  = fsel_q.clockGenTestOutEn && isSpecial && !isSingle && !pipeOn;
    wire clkOn  = isExpanded ||
                  (isSingle && !fsel_q.busClockPinDisable && (internal_visibility_q || !clock_stretch_select_q));
    wire strbOn = fsel_q.lowStrobePinEn && !isSingle &&
                  (opMode_q != port_e_pkg::ModeNormExpNar);
    wire rwOn   = fsel_q.readWritePinEn && !isSingle;
    wire dbeOn  = !fsel_q.dataBusEnableDisable;
    wire [7:0] altOn  = {dbeOn, pipeOn | cgmOn, pipeOn, clkOn, strbOn, rwOn, 2'b00};
    wire [7:0] altVal = {dataEnableOut, pipeOn ? pipeStatus[1] : clockGenTest, pipeStatus[0],
                         busClk, lowByteStrobe, rdWr, 2'b00};
    wire [7:0] gpioOe = dir_q & ~altOn & ~port_e_pkg::InputOnlyMask;

    // pad drive: alternate function overrides direction
    assign pinOe    = altOn | gpioOe;
    assign pinOut   = (altOn & altVal) | (gpioOe & gpioOut);
    assign pinLevel = pinSync_q;

    // pull-ups only on inputs; wide ports lose them while they carry the bus
    assign pullEnE = ({8{pull_q[port_e_pkg::CtrlPortBit]}} & port_e_pkg::PullableMask & ~pinOe) |
                     port_e_pkg::AlwaysPullMsk;
    assign pullEnA = {8{pull_q[port_e_pkg::HighPortBit] && !isExpanded}} & ~portADir;
    assign pullEnB = {8{pull_q[port_e_pkg::LowPortBit] && !isExpanded}} & ~portBDir;

    // reduced drive applies to whole ports whatever the pin function
    assign lowDriveE = drive_q[port_e_pkg::CtrlPortBit];
    assign lowDriveA = drive_q[port_e_pkg::HighPortBit];
    assign lowDriveB = drive_q[port_e_pkg::LowPortBit];
    assign emulateCtrlPort = isExpanded && eme_q;

    // low-byte tag sampled at the falling edge of the bus clock
    logic busClkPrev_q;
    logic tag_q;
    wire  tagOn = strbOn && isSpecial && isExpanded && tagEnable;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busClkPrev_q <= 1'b0;
            tag_q        <= 1'b0;
        end else begin
            busClkPrev_q <= busClk;
            if (busClkPrev_q && !busClk) begin
                tag_q <= tagOn && !pinSync_q[3];
            end
        end
    end
    assign lowByteTagInput = tag_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence hiddenWrite;
        doWrite && (wSel == 4'h0);
    endsequence
    sequence decErrAnswer;
        s_axi_bvalid && (s_axi_bresp == port_e_pkg::RespDecErr) && $stable(dir_q);
    endsequence
    sequence lockedFselWrite;
        wrFsel && !isSpecial && fselOnce_q;
    endsequence

    a_input_only_pins: assert property (pinOe[1:0] == 2'b00)
        else $error("interrupt pins driven");
    a_gpio_follows_dir: assert property (
        fsel_q.dataBusEnableDisable |-> pinOe[7] == dir_q[7])
        else $error("gpio pin 7 enable differs from direction");
    a_alt_over_dir: assert property (
        fsel_q.readWritePinEn && !isSingle |-> pinOe[2] && pinOut[2] == rdWr)
        else $error("read/write function not on pin 2");
    a_clkdis_held_low: assert property (isExpanded |-> !fsel_q.busClockPinDisable)
        else $error("clock disable set in expanded mode");
    a_pipe_over_test: assert property (
        fsel_q.pipeStatusOutEn && !isSingle |-> pinOe[6] && pinOut[6] == pipeStatus[1])
        else $error("pipe status not on pin 6");
    a_clock_single_gate: assert property (
        isSingle && fsel_q.busClockPinDisable && !dir_q[4] |-> !pinOe[4])
        else $error("bus clock driven while disabled");
    a_pullup_fixed: assert property (pullEnE[1] && pullEnE[6:4] == 3'b000)
        else $error("fixed pull-up pattern broken");
    a_hidden_decerr: assert property (hiddenWrite |=> decErrAnswer)
        else $error("absent register write not refused");
    a_fsel_once_lock: assert property (
        lockedFselWrite |=> $stable(fsel_q.readWritePinEn) && $stable(fsel_q.lowStrobePinEn))
        else $error("locked function select changed");
    a_drive_first_skip: assert property (
        wrDrive && isSpecial && !driveOnce_q |=> $stable(drive_q) ##1 driveOnce_q)
        else $error("first special drive write took effect");
    a_bus_port_pullup: assert property (
        isExpanded |-> pullEnA == 8'h00 && pullEnB == 8'h00)
        else $error("pull-up on address/data port");
    a_ctrl_pull_inputs: assert property ((pullEnE & pinOe) == 8'h00)
        else $error("pull-up on driven pin");

endmodule

// File: verification/bus_ctrl_model.sv
// partner model: bus-control sources and the pads beyond the control port
`timescale 1ns/100ps
module bus_ctrl_model (
    input  wire logic       ref_clk,       // system clock
    input  wire logic [7:0] pinOe,         // pad enables from the block
    input  wire logic [7:0] pinOut,        // pad values from the block
    output logic            busClk,        // bus clock
    output logic            rdWr,          // read/write
    output logic            dataEnableOut, // memory data enable
    output logic            lowByteStrobe, // low-byte strobe
    output logic [1:0]      pipeStatus,    // instruction queue state
    output logic            clockGenTest,  // clock generator test signal
    output logic            tagEnable,     // debug tagging on
    output logic [7:0]      pinIn          // resolved pad levels
);
    logic [3:0] cntQ = 4'h0;
    // free-running counter gives every bus source but tagEnable its own pattern; tagEnable is tied high
    always @(posedge ref_clk) cntQ <= cntQ + 4'h1;
    assign busClk        = cntQ[0];
    assign rdWr          = cntQ[1];
    assign dataEnableOut = cntQ[2];
    assign lowByteStrobe = ~cntQ[1];
    assign pipeStatus    = cntQ[3:2];
    assign clockGenTest  = ~cntQ[0];
    assign tagEnable     = 1'b1;
    // released pads sit at the pull-up level; the tagger pulls pin 3 low while clock is low and cntQ[2] is high
    always_comb begin
        for (int i = 0; i < 8; i++) pinIn[i] = pinOe[i] ? pinOut[i] : 1'b1;
        if (!pinOe[3] && !busClk && cntQ[2]) pinIn[3] = 1'b0;
    end
endmodule

// File: verification/port_e_function_and_pad_control_tb.sv
// self-checking bench for the control-port mux and its register slave
`timescale 1ns/100ps
module port_e_function_and_pad_control_tb;
    logic ref_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, pinIn, pinOut, pinOe, pullEnE;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'h1;
    logic [2:0] modePins = 0;
    logic [1:0] bresp, rresp, pipeStatus;
    logic awready, wready, bvalid, arready, rvalid, lowDriveE, lowDriveA, lowDriveB, emu;
    logic busClk, rdWr, dataEn, lowStrb, cgTest, tagEn, tag;
    logic [7:0] pinLevel, pullEnA, pullEnB;
    int mismatches = 0, samplesChecked = 0;
    always #5 ref_clk = ~ref_clk;
    port_e_function_and_pad_control i_port_e_function_and_pad_control (.ref_clk(ref_clk),
        .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .modePins(modePins), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .pinLevel(pinLevel), .gpioOut(8'h5A), .pullEnE(pullEnE), .pullEnA(pullEnA),
        .pullEnB(pullEnB), .portADir(8'h0F), .portBDir(8'hF0), .lowDriveE(lowDriveE),
        .lowDriveA(lowDriveA), .lowDriveB(lowDriveB),
        .dataEnableOut(dataEn), .busClk(busClk), .rdWr(rdWr), .lowByteStrobe(lowStrb),
        .pipeStatus(pipeStatus), .clockGenTest(cgTest), .tagEnable(tagEn),
        .lowByteTagInput(tag), .emulateCtrlPort(emu));
    bus_ctrl_model i_bus_ctrl_model (.ref_clk(ref_clk), .pinOe(pinOe), .pinOut(pinOut),
        .busClk(busClk), .rdWr(rdWr), .dataEnableOut(dataEn), .lowByteStrobe(lowStrb),
        .pipeStatus(pipeStatus), .clockGenTest(cgTest), .tagEnable(tagEn), .pinIn(pinIn));
    // compare one value and count it
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && samplesChecked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // reset with the given mode straps
    task automatic do_reset(input logic [2:0] m);
        @(posedge ref_clk);
        rst_n <= 0;
        modePins <= m;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1;
    endtask
    // one write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk("bresp", bresp, r);
    endtask
    // one read, comparing data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        chk("rdata", rdata, d);
        chk("rresp", rresp, r);
    endtask
    // reset value of function select per mode
    task automatic t_reset_values();
        do_reset(port_e_pkg::ModeNormExpNar);
        rd(8'h04, 32'h0000_0080, 2'h0);
        chk("pinOe", pinOe, 32'h0000_0010);
        do_reset(port_e_pkg::ModeSpecSingle);
        rd(8'h04, 32'h0000_0080, 2'h0);
    endtask
    // normal single chip: direction, once bits, pull-ups, drive, unmapped place
    task automatic t_norm_single();
        do_reset(port_e_pkg::ModeNormSingle);
        rd(8'h04, 32'h0000_0090, 2'h0);
        wr(8'h00, 32'h0000_00FF, 4'h1, 2'h0);
        rd(8'h00, 32'h0000_00FC, 2'h0);
        chk("pinOe", pinOe, 32'h0000_00FC);
        chk("pullEnE", pullEnE, 32'h0000_0002);
        chk("pinLevel", pinLevel, 32'h0000_005B);
        wr(8'h04, 32'h0000_0000, 4'h1, 2'h0);
        wr(8'h04, 32'h0000_00FC, 4'h1, 2'h0);
        rd(8'h04, 32'h0000_0000, 2'h0);
        wr(8'h00, 32'h0000_0080, 4'h1, 2'h0);
        wr(8'h08, 32'h0000_0013, 4'h1, 2'h0);
        #1;
        chk("pullEnE", pullEnE, 32'h0000_000F);
        chk("pullEnAB", {pullEnA, pullEnB}, 32'h0000_F00F);
        wr(8'h04, 32'h0000_0100, 4'h2, 2'h0);
        #1;
        chk("pinOe", pinOe, 32'h0000_0080);
        wr(8'h0C, 32'h0000_0013, 4'h1, 2'h0);
        wr(8'h0C, 32'h0000_0000, 4'h1, 2'h0);
        #1;
        chk("lowDrive", {lowDriveE, lowDriveB, lowDriveA}, 32'h0000_0007);
        rd(8'h10, 32'h0000_0000, port_e_pkg::RespDecErr);
    endtask
    // special expanded: reset functions, first write ignored, emulation bit
    task automatic t_spec_exp();
        do_reset(port_e_pkg::ModeSpecExpWide);
        rd(8'h04, 32'h0000_00AC, 2'h0);
        #1;
        chk("pinOe", pinOe, 32'h0000_007C);
        wr(8'h08, 32'h0000_0013, 4'h1, 2'h0);
        #1;
        chk("pullEnAB", {pullEnA, pullEnB}, 32'h0000_0000);
        wr(8'h04, 32'h0000_0000, 4'h1, 2'h0);
        rd(8'h04, 32'h0000_00AC, 2'h0);
        wr(8'h04, 32'h0000_00D0, 4'h1, 2'h0);
        rd(8'h04, 32'h0000_00C0, 2'h0);
        #1;
        chk("pinOe", pinOe, 32'h0000_0050);
        chk("pin6", pinOut[6], cgTest);
        chk("tag", tag, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0013, 4'h1, 2'h0);
        wr(8'h0C, 32'h0000_0002, 4'h1, 2'h0);
        rd(8'h0C, 32'h0000_0002, 2'h0);
        wr(8'h04, 32'h0000_0200, 4'h2, 2'h0);
        #1;
        chk("emulate", emu, 32'h0000_0001);
        rd(8'h00, 32'h0000_0000, port_e_pkg::RespDecErr);
    endtask
    // peripheral mode: the function-select, pull and drive registers are gone
    task automatic t_periph();
        do_reset(port_e_pkg::ModePeriph);
        rd(8'h04, 32'h0000_0000, port_e_pkg::RespDecErr);
        wr(8'h04, 32'h0000_00FF, 4'h1, port_e_pkg::RespDecErr);
        rd(8'h08, 32'h0000_0000, port_e_pkg::RespDecErr);
        rd(8'h0C, 32'h0000_0000, port_e_pkg::RespDecErr);
    endtask
    initial begin
        t_reset_values();
        t_norm_single();
        t_spec_exp();
        t_periph();
        final_report();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        final_report();
    end
endmodule
